/* core/arss_sequencer.v */
// autoreclose shot sequencer with register port
//
// Decided for this implementation: strobed register access and the placing of the registers.
`default_nettype none
`include "arss_defines.vh"
module arss_sequencer #(
    parameter RESET_CYCLES = `ARSS_RESET_TIME_S * `ARSS_CLK_KHZ * 1000,
    parameter STEP_CYCLES = `ARSS_STEP_MS * `ARSS_CLK_KHZ
) (
    input wire clk_sys,
    input wire rst_b,
    input wire [5:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    output reg irq,
    input wire inst_oc_op,
    input wire time_oc_op,
    input wire brk_open_pin,
    input wire [2:0] sup_limit,
    input wire lockout_demand,
    output reg brk_trip,
    output reg brk_close,
    output reg oc_reset,
    output reg [4:0] inst_block,
    output reg [34:0] time_raise,
    output reg [2:0] group_sel,
    output reg group_sel_valid,
    output reg lockout
);
    // ************************************************************
    // sequencer state codes
    // ************************************************************
    localparam ST_IDLE = 3'h0;
    localparam ST_WAIT_OPEN = 3'h1;
    localparam ST_DEAD = 3'h2;
    localparam ST_RECLOSED = 3'h3;
    localparam ST_LOCKOUT = 3'h4;

    // ************************************************************
    // settings storage
    // ************************************************************
    reg [14:0] wait_q [0:3];
    reg [4:0] blk_q [0:3];
    reg [34:0] raise_q [0:3];
    reg [2:0] grp_q [0:3];
    reg enable_q;
    reg [2:0] maxshot_q;
    reg [3:0] irq_stat_q;
    reg [3:0] irq_mask_q;
    reg [2:0] state_q;
    reg [2:0] shot_q;
    reg [2:0] limit_q;
    reg [14:0] wait_cnt_q;
    reg [31:0] tick_cnt_q;
    reg [31:0] rst_cnt_q;
    reg [2:0] open_sync_q;
    reg open_q;
    reg [3:0] ev_d;

    // ************************************************************
    // decoded strobes, shot index and limits
    // ************************************************************
    wire shot_wr = reg_wr && (reg_addr[5:4] == 2'h1);
    wire [1:0] wr_shot = reg_addr[3:2];
    wire [1:0] sel = shot_q[1:0] - 2'h1;
    wire tick = (tick_cnt_q == STEP_CYCLES - 1);
    wire trip_ev = inst_oc_op || time_oc_op;
    wire [2:0] eff_max = (sup_limit < maxshot_q) ? sup_limit : maxshot_q;
    wire ctrl_reset = reg_wr && (reg_addr == `ARSS_REG_CTRL) && reg_wdata[`ARSS_CTRL_RESET_LO];
    wire in_shot = (shot_q != 3'h0) && (shot_q <= limit_q) && (state_q != ST_IDLE);

    // ************************************************************
    // per-shot setting writes
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_shot
            always @(posedge clk_sys) begin
                if (!rst_b) begin
                    wait_q[g] <= `ARSS_WAIT_RST;
                    blk_q[g] <= 5'h00;
                    raise_q[g] <= 35'h0;
                    grp_q[g] <= `ARSS_GROUP_ACTIVE;
                end else if (shot_wr && wr_shot == g) begin
                    case (reg_addr[1:0])
                        `ARSS_SHOT_WAIT: begin
                            if (reg_wdata[14:0] <= `ARSS_WAIT_MAX) begin
                                wait_q[g] <= reg_wdata[14:0];
                            end
                        end
                        `ARSS_SHOT_BLOCK: begin
                            blk_q[g] <= reg_wdata[4:0];
                            if (reg_wdata[10:8] <= 3'h4) begin
                                grp_q[g] <= reg_wdata[10:8];
                            end
                        end
                        `ARSS_SHOT_RAISE_LO: begin
                            if (reg_wdata[6:0] <= `ARSS_PCT_MAX) raise_q[g][6:0] <= reg_wdata[6:0];
                            if (reg_wdata[14:8] <= `ARSS_PCT_MAX) raise_q[g][13:7] <= reg_wdata[14:8];
                            if (reg_wdata[22:16] <= `ARSS_PCT_MAX) raise_q[g][20:14] <= reg_wdata[22:16];
                            if (reg_wdata[30:24] <= `ARSS_PCT_MAX) raise_q[g][27:21] <= reg_wdata[30:24];
                        end
                        default: begin
                            if (reg_wdata[6:0] <= `ARSS_PCT_MAX) raise_q[g][34:28] <= reg_wdata[6:0];
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ************************************************************
    // breaker status input synchroniser
    // ************************************************************
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            open_sync_q <= 3'h0;
            open_q <= 1'b0;
        end else begin
            open_sync_q <= {open_sync_q[1:0], brk_open_pin};
            if (open_sync_q[2] == open_sync_q[1]) begin
                open_q <= open_sync_q[2];
            end
        end
    end

    // ************************************************************
    // shot sequencer
    // ************************************************************
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            shot_q <= 3'h0;
            limit_q <= `ARSS_MAXSHOT_RST;
            wait_cnt_q <= 15'h0;
            rst_cnt_q <= 32'h0;
            brk_trip <= 1'b0;
            brk_close <= 1'b0;
            lockout <= 1'b0;
            ev_d <= 4'h0;
        end else begin
            ev_d <= 4'h0;
            brk_close <= 1'b0;
            case (state_q)
                ST_IDLE, ST_RECLOSED: begin
                    if (lockout_demand && state_q == ST_RECLOSED) begin
                        state_q <= ST_LOCKOUT;
                        lockout <= 1'b1;
                        ev_d[`ARSS_EV_LOCKOUT] <= 1'b1;
                    end else if (enable_q && trip_ev) begin
                        brk_trip <= 1'b1;
                        ev_d[`ARSS_EV_TRIP] <= 1'b1;
                        limit_q <= (state_q == ST_IDLE || eff_max < limit_q) ? eff_max : limit_q;
                        if (lockout_demand || shot_q >= eff_max || shot_q >= limit_q) begin
                            state_q <= ST_LOCKOUT;
                            lockout <= 1'b1;
                            ev_d[`ARSS_EV_LOCKOUT] <= 1'b1;
                        end else begin
                            state_q <= ST_WAIT_OPEN;
                        end
                    end else if (state_q == ST_RECLOSED) begin
                        if (rst_cnt_q >= RESET_CYCLES - 1) begin
                            state_q <= ST_IDLE;
                            shot_q <= 3'h0;
                            ev_d[`ARSS_EV_SCHEME_RESET] <= 1'b1;
                        end else begin
                            rst_cnt_q <= rst_cnt_q + 32'h1;
                        end
                    end
                end
                ST_WAIT_OPEN: begin
                    if (lockout_demand) begin
                        state_q <= ST_LOCKOUT;
                        lockout <= 1'b1;
                        ev_d[`ARSS_EV_LOCKOUT] <= 1'b1;
                    end else if (open_q) begin
                        brk_trip <= 1'b0;
                        wait_cnt_q <= 15'h0;
                        state_q <= ST_DEAD;
                    end
                end
                ST_DEAD: begin
                    if (lockout_demand) begin
                        state_q <= ST_LOCKOUT;
                        lockout <= 1'b1;
                        ev_d[`ARSS_EV_LOCKOUT] <= 1'b1;
                    end else if (wait_cnt_q >= wait_q[shot_q[1:0]]) begin
                        brk_close <= 1'b1;
                        shot_q <= shot_q + 3'h1;
                        rst_cnt_q <= 32'h0;
                        ev_d[`ARSS_EV_CLOSE] <= 1'b1;
                        state_q <= ST_RECLOSED;
                    end else if (tick) begin
                        wait_cnt_q <= wait_cnt_q + 15'h1;
                    end
                end
                ST_LOCKOUT: begin
                    brk_trip <= 1'b0;
                    if (ctrl_reset) begin
                        lockout <= 1'b0;
                        shot_q <= 3'h0;
                        state_q <= ST_IDLE;
                        ev_d[`ARSS_EV_SCHEME_RESET] <= 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // wait step divider, restarted as the dead time begins
    // ************************************************************
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            tick_cnt_q <= 32'h0;
        end else if (tick || (state_q == ST_WAIT_OPEN && open_q && !lockout_demand)) begin
            tick_cnt_q <= 32'h0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
        end
    end

    // ************************************************************
    // per-shot protection modifications
    // ************************************************************
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            inst_block <= 5'h00;
            time_raise <= 35'h0;
            group_sel <= `ARSS_GROUP_ACTIVE;
            group_sel_valid <= 1'b0;
            oc_reset <= 1'b0;
        end else begin
            oc_reset <= open_q;
            if (in_shot) begin
                inst_block <= blk_q[sel];
                time_raise <= raise_q[sel];
                group_sel <= grp_q[sel];
                group_sel_valid <= (grp_q[sel] != `ARSS_GROUP_ACTIVE);
            end else begin
                inst_block <= 5'h00;
                time_raise <= 35'h0;
                group_sel <= `ARSS_GROUP_ACTIVE;
                group_sel_valid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // control and mask registers
    // ************************************************************
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            enable_q <= 1'b0;
            maxshot_q <= `ARSS_MAXSHOT_RST;
            irq_mask_q <= 4'h0;
        end else begin
            if (reg_wr && reg_addr == `ARSS_REG_CTRL) begin
                enable_q <= reg_wdata[`ARSS_CTRL_ENABLE];
                // a shot count of zero or above four is refused
                if (reg_wdata[3:1] >= 3'h1 && reg_wdata[3:1] <= 3'h4) begin
                    maxshot_q <= reg_wdata[3:1];
                end
            end
            if (reg_wr && reg_addr == `ARSS_REG_IRQ_MASK) begin
                irq_mask_q <= reg_wdata[3:0];
            end
        end
    end

    // ************************************************************
    // interrupt status, a set wins over a clear in one cycle
    // ************************************************************
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            irq_stat_q <= 4'h0;
            irq <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `ARSS_REG_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~reg_wdata[3:0]) | ev_d;
            end else begin
                irq_stat_q <= irq_stat_q | ev_d;
            end
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ************************************************************
    // read data, zero outside the cycle after a read strobe
    // ************************************************************
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= 32'h0;
            if (reg_rd) begin
                case (reg_addr)
                    `ARSS_REG_CTRL: reg_rdata <= {28'h0, maxshot_q, enable_q};
                    `ARSS_REG_STAT: reg_rdata <= {20'h0, limit_q, lockout, 1'b0, shot_q, 1'b0, state_q};
                    `ARSS_REG_IRQ_STAT: reg_rdata <= {28'h0, irq_stat_q};
                    `ARSS_REG_IRQ_MASK: reg_rdata <= {28'h0, irq_mask_q};
                    default: begin
                        if (reg_addr[5:4] == 2'h1) begin
                            case (reg_addr[1:0])
                                `ARSS_SHOT_WAIT: reg_rdata <= {17'h0, wait_q[reg_addr[3:2]]};
                                `ARSS_SHOT_BLOCK: reg_rdata <= {21'h0, grp_q[reg_addr[3:2]], 3'h0,
                                    blk_q[reg_addr[3:2]]};
                                `ARSS_SHOT_RAISE_LO: reg_rdata <= {1'b0, raise_q[reg_addr[3:2]][27:21],
                                    1'b0, raise_q[reg_addr[3:2]][20:14], 1'b0, raise_q[reg_addr[3:2]][13:7],
                                    1'b0, raise_q[reg_addr[3:2]][6:0]};
                                default: reg_rdata <= {25'h0, raise_q[reg_addr[3:2]][34:28]};
                            endcase
                        end
                    end
                endcase
            end
        end
    end
endmodule // arss_sequencer
`default_nettype wire

/* core/arss_defines.vh */
// constants for the autoreclose shot sequencer
`ifndef ARSS_DEFINES_VH
`define ARSS_DEFINES_VH
// register word indices
`define ARSS_REG_CTRL 6'h00
`define ARSS_REG_STAT 6'h01
`define ARSS_REG_IRQ_STAT 6'h02
`define ARSS_REG_IRQ_MASK 6'h03
`define ARSS_REG_SHOT_BASE 6'h10
// per-shot registers: base + shot*4 + field
`define ARSS_SHOT_WAIT 2'h0
`define ARSS_SHOT_BLOCK 2'h1
`define ARSS_SHOT_RAISE_LO 2'h2
`define ARSS_SHOT_RAISE_HI 2'h3
// control register fields
`define ARSS_CTRL_ENABLE 0
`define ARSS_CTRL_MAXSHOT_LSB 1
`define ARSS_CTRL_RESET_LO 4
// reset values and setting limits
`define ARSS_MAXSHOT_RST 3'h4
`define ARSS_WAIT_RST 15'h0032
`define ARSS_WAIT_MAX 15'h7530
`define ARSS_PCT_MAX 7'h64
`define ARSS_GROUP_ACTIVE 3'h0
// timing: one wait step is 10 ms
`define ARSS_STEP_MS 10
`define ARSS_CLK_KHZ 20000
`define ARSS_RESET_TIME_S 60
// event bits
`define ARSS_EV_TRIP 0
`define ARSS_EV_CLOSE 1
`define ARSS_EV_LOCKOUT 2
`define ARSS_EV_SCHEME_RESET 3
`endif

/* bench/arss_assertions.sv */
// port checker for the autoreclose shot sequencer
`default_nettype none
module arss_assertions (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [5:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic inst_oc_op,
    input wire logic time_oc_op,
    input wire logic brk_open_pin,
    input wire logic brk_trip,
    input wire logic brk_close,
    input wire logic oc_reset,
    input wire logic [4:0] inst_block,
    input wire logic [34:0] time_raise,
    input wire logic [2:0] group_sel,
    input wire logic group_sel_valid,
    input wire logic lockout
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    property p_trip_cause; $rose(brk_trip) |-> $past(inst_oc_op || time_oc_op) || lockout; endproperty
    a_trip_cause: assert property (p_trip_cause) else $error("trip without cause");
    property p_close_pulse; brk_close |=> !brk_close; endproperty
    a_close_pulse: assert property (p_close_pulse) else $error("close longer than one cycle");
    property p_close_open; brk_close |-> oc_reset && !brk_trip; endproperty
    a_close_open: assert property (p_close_open) else $error("close while breaker not open");
    property p_no_close_lock; lockout |-> !brk_close; endproperty
    a_no_close_lock: assert property (p_no_close_lock) else $error("close in lockout");
    property p_lock_hold; $fell(lockout) |-> $past(reg_wr && reg_addr == 6'h00 && reg_wdata[4]); endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lockout left without reset");
    property p_oc_reset; $rose(oc_reset) |-> $past(brk_open_pin, 3); endproperty
    a_oc_reset: assert property (p_oc_reset) else $error("element reset without open breaker");
    property p_block_chg; $changed(inst_block) |-> $past(brk_close) || inst_block == 5'h00; endproperty
    a_block_chg: assert property (p_block_chg) else $error("blocking changed outside shot change");
    property p_raise_chg; $changed(time_raise) |-> $past(brk_close) || time_raise == 35'h0; endproperty
    a_raise_chg: assert property (p_raise_chg) else $error("raise changed outside shot change");
    property p_grp_valid; group_sel_valid == (group_sel != 3'h0); endproperty
    a_grp_valid: assert property (p_grp_valid) else $error("group valid mismatch");
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
endmodule // arss_assertions
bind arss_sequencer arss_assertions u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .inst_oc_op(inst_oc_op),
    .time_oc_op(time_oc_op), .brk_open_pin(brk_open_pin), .brk_trip(brk_trip), .brk_close(brk_close),
    .oc_reset(oc_reset), .inst_block(inst_block), .time_raise(time_raise), .group_sel(group_sel),
    .group_sel_valid(group_sel_valid), .lockout(lockout));
`default_nettype wire

/* bench/arss_breaker_model.sv */
// behavioural breaker: opens after trip, closes after close pulse
`default_nettype none
module arss_breaker_model #(
    parameter int DLY = 3
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic brk_trip,
    input wire logic brk_close,
    output logic brk_open_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    logic want_open;
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            brk_open_pin <= 1'b0;
            want_open <= 1'b0;
            cnt <= 0;
        end else begin
            if (brk_trip && !brk_open_pin) want_open <= 1'b1;
            if (brk_close) want_open <= 1'b0;
            // contacts move a few cycles after the command
            if (want_open != brk_open_pin) cnt <= cnt + 1;
            else cnt <= 0;
            if (cnt == DLY) brk_open_pin <= want_open;
        end
    end
endmodule // arss_breaker_model
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the autoreclose shot sequencer
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq, brk_trip, brk_close, oc_reset;
    logic [5:0] reg_addr = 6'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_v;
    logic inst_oc_op = 1'b0, time_oc_op = 1'b0, lockout_demand = 1'b0, brk_open_pin, group_sel_valid, lockout;
    logic [2:0] sup_limit = 3'h4, group_sel;
    logic [4:0] inst_block;
    logic [34:0] time_raise;
    int fails = 0, num_checks = 0, cyc = 0;
    always #25 clk_sys = ~clk_sys;
    arss_sequencer #(.RESET_CYCLES(300), .STEP_CYCLES(4)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .inst_oc_op(inst_oc_op), .time_oc_op(time_oc_op), .brk_open_pin(brk_open_pin),
        .sup_limit(sup_limit), .lockout_demand(lockout_demand), .brk_trip(brk_trip), .brk_close(brk_close),
        .oc_reset(oc_reset), .inst_block(inst_block), .time_raise(time_raise), .group_sel(group_sel),
        .group_sel_valid(group_sel_valid), .lockout(lockout));
    arss_breaker_model u_brk (.clk_sys(clk_sys), .rst_b(rst_b), .brk_trip(brk_trip), .brk_close(brk_close),
        .brk_open_pin(brk_open_pin));
    // ****************
    // helpers
    // ****************
    task chk(input string nm, input logic [34:0] seen, input logic [34:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [5:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask
    task automatic wait_hi(ref logic s, input string nm);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk(nm, s, 1'b1);
    endtask
    task fault(input logic timed);
        repeat (30) @(posedge clk_sys);
        if (timed) time_oc_op <= 1'b1;
        else inst_oc_op <= 1'b1;
        @(posedge clk_sys);
        time_oc_op <= 1'b0;
        inst_oc_op <= 1'b0;
        #1;
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            report_and_stop;
        end
    end
    // ****************
    // scenarios
    // ****************
    task t_regs;
        rd(6'h00);
        chk("ctrl reset", rd_v, 32'h8);
        rd(6'h10);
        chk("wait reset", rd_v, 32'h32);
        wr(6'h10, 32'h7531);
        rd(6'h10);
        chk("wait refused", rd_v, 32'h32);
        rd(6'h3f);
        chk("unmapped", rd_v, 32'h0);
        wr(6'h10, 32'h5);
        wr(6'h11, 32'h21f);
        wr(6'h12, 32'h64);
        wr(6'h14, 32'h3);
        wr(6'h15, 32'h1);
        wr(6'h19, 32'h31f);
        wr(6'h03, 32'h5);
        wr(6'h00, 32'h5);
        chk("block default", inst_block, 5'h0);
        $display("t_regs done");
    endtask
    task t_shots;
        fault(1'b0);
        chk("trip on inst", brk_trip, 1'b1);
        wait_hi(brk_close, "close 1");
        @(posedge clk_sys);
        #1 chk("block shot1", inst_block, 5'h1f);
        chk("raise shot1", time_raise, 35'h64);
        chk("group shot1", group_sel, 3'h2);
        chk("elements reset", oc_reset, 1'b1);
        rd(6'h01);
        chk("shot count", rd_v[6:4], 3'h1);
        fault(1'b1);
        chk("trip on time", brk_trip, 1'b1);
        wait_hi(brk_close, "close 2");
        @(posedge clk_sys);
        #1 chk("block shot2", inst_block, 5'h01);
        chk("group active", group_sel_valid, 1'b0);
        fault(1'b1);
        wait_hi(lockout, "lockout");
        chk("irq", irq, 1'b1);
        repeat (60) @(posedge clk_sys);
        #1 chk("held", lockout, 1'b1);
        chk("shot3 unused", inst_block !== 5'h1f, 1'b1);
        wr(6'h02, 32'hf);
        repeat (3) @(posedge clk_sys);
        #1 chk("irq cleared", irq, 1'b0);
        wr(6'h00, 32'h15);
        #1 chk("lock reset", lockout, 1'b0);
        $display("t_shots done");
    endtask
    task t_reset;
        repeat (20) @(posedge clk_sys);
        fault(1'b0);
        wait_hi(brk_close, "close 3");
        repeat (400) @(posedge clk_sys);
        #1 chk("unblocked", inst_block, 5'h0);
        chk("normal raise", time_raise, 35'h0);
        rd(6'h01);
        chk("count clear", rd_v[6:4], 3'h0);
        $display("t_reset done");
    endtask
    task t_limit;
        sup_limit <= 3'h1;
        fault(1'b0);
        wait_hi(brk_close, "close 4");
        fault(1'b1);
        wait_hi(lockout, "sup lockout");
        wr(6'h00, 32'h15);
        sup_limit <= 3'h4;
        fault(1'b0);
        lockout_demand <= 1'b1;
        wait_hi(lockout, "demand lockout");
        lockout_demand <= 1'b0;
        $display("t_limit done");
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_regs;
        t_shots;
        t_reset;
        t_limit;
        report_and_stop;
    end
endmodule // tb
`default_nettype wire
